// ---- logic/pitb_map.svh ----
// register offsets, field positions, reset values and source indices
// assumes a 32-bit bus with one register in each aligned word
`ifndef PITB_MAP_SVH
`define PITB_MAP_SVH
`define PITB_OFS_CTL0    8'h00
`define PITB_OFS_CTL1    8'h04
`define PITB_OFS_CTL2    8'h08
`define PITB_OFS_CTL3    8'h0C
`define PITB_OFS_PSC     8'h10
`define PITB_OFS_TB0     8'h14
`define PITB_OFS_TB1     8'h18
`define PITB_OFS_PEND    8'h1C
`define PITB_RST_BYTE    8'h00
`define PITB_RST_SRC     11'h000
`define PITB_C0_SERF     6
`define PITB_C0_SERE     3
`define PITB_C0_GIE      0
`define PITB_C12_FHI     7
`define PITB_C12_FLO     4
`define PITB_C12_EHI     3
`define PITB_C12_ELO     0
`define PITB_C3_URTF     5
`define PITB_C3_TICK1_REQUEST_FLAG     4
`define PITB_C3_URTE     1
`define PITB_C3_TICK1_IRQ_ENABLE     0
`define PITB_TB_RUN      7
`define PITB_TB_PHI      2
`define PITB_TB_PLO      0
`define PITB_PSC_HI      1
`define PITB_PSC_LO      0
`define PITB_PSC_SYS     2'h0
`define PITB_PSC_DIV4    2'h1
`define PITB_DIV4_LAST   2'h3
`define PITB_TB_FULL     15'h7FFF
`define PITB_TB_TOPSEL   3'h7
`define PITB_SRC_SER     0
`define PITB_SRC_LOW     1
`define PITB_SRC_CONV    2
`define PITB_SRC_EE      3
`define PITB_SRC_TB0     4
`define PITB_SRC_T0A     5
`define PITB_SRC_T0P     6
`define PITB_SRC_T1A     7
`define PITB_SRC_T1P     8
`define PITB_SRC_TB1     9
`define PITB_SRC_URT     10
`endif

// ---- logic/pitb_pkg.sv ----
// types shared by the interrupt and time base block and its bench
// assumes the map header supplies every register number; the mode and state codes are set here
package pitb_pkg;
	typedef enum logic [1:0] {
		PITB_MODE_SPI  = 2'h0,
		PITB_MODE_I2C  = 2'h1,
		PITB_MODE_UART = 2'h2
	} pitb_mode_t;
	typedef enum logic [1:0] {
		PITB_ST_IDLE = 2'b01,
		PITB_ST_REQ  = 2'b10
	} pitb_state_t;
	typedef struct packed {
		pitb_mode_t  serial_mode;
		logic        sio_byte_done;
		logic        i2c_addr_match;
		logic        i2c_timeout;
		logic [5:0]  uart_cond;
		logic        low_supply;
		logic        conv_done;
		logic        eeprom_wr_done;
		logic [3:0]  tmr_match;
	} pitb_evt_t;
	typedef struct packed {
		logic stack_full;
		logic ack;
		logic reti;
	} pitb_cpu_t;
endpackage

// ---- logic/pitb_top.sv ----
// peripheral interrupt request logic with two time base generators
// assumes synchronous peripheral event levels, an AHB-Lite master and a sequencer acking requests
// What this block does
// RL1 - serial flag set in SPI/I2C events
// RL2 - serial flag set by UART conditions
// RL3 - vector needs global, enable, flag, stack room
// RL4 - serial service clears flag and global enable
// RL5 - service leaves UART status flags alone
// RL6 - UART condition sent as low pulse
// RL7 - UART vectors gated; service clears flag, global
// RL8 - low supply sets flag, cleared on service
// RL9 - conversion done sets flag, auto cleared
// RL10 - EEPROM write end sets flag, auto cleared
// RL11 - two timers, A and P match sources
// RL12 - timer match service clears flag, global
// RL13 - time base overflow sets its flag
// RL14 - time base gated; service clears flag, global
// RL15 - prescaler source: sys, sys/4, sub clock
// RL16 - both units divide shared prescaler clock
// RL17 - bit 7 enables time base 0
// RL18 - period is 2^(8+field) prescaler clocks
// RL19 - time base 1 same layout and encoding
// RL20 - global disable blocks all, flags still record
// RL21 - any rising flag wakes the device
// RL22 - lowest vector first when several pend
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "pitb_map.svh"
module pitb_top #(
	parameter int NSRC = 11
) (
	input  wire  logic                 clk,
	input  wire  logic                 sys_rst,
	input  wire  logic                 hsel,
	input  wire  logic [31:0]          haddr,
	input  wire  logic [1:0]           htrans,
	input  wire  logic                 hwrite,
	input  wire  logic [2:0]           hsize,
	input  wire  logic [31:0]          hwdata,
	input  wire  logic                 hready,
	output logic       [31:0]          hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire  pitb_pkg::pitb_evt_t  evt,
	input  wire  logic                 sub_tick,
	input  wire  pitb_pkg::pitb_cpu_t  cpu,
	output logic                       irq_req,
	output logic       [3:0]           irq_vector,
	output logic                       wake
);
	import pitb_pkg::*;

	pitb_state_t       state_reg;
	logic [NSRC-1:0]   flags_reg;
	logic [NSRC-1:0]   flags_next;
	logic [NSRC-1:0]   en_reg;
	logic [NSRC-1:0]   set_vec;
	logic [NSRC-1:0]   clr_vec;
	logic [NSRC-1:0]   pend;
	logic [3:0]        lowest;
	logic              gie_reg;
	logic              irq_req_reg;
	logic [3:0]        irq_vec_reg;
	logic              wake_reg;
	logic              wr_pend_reg;
	logic [7:0]        wr_addr_reg;
	logic [31:0]       hrdata_reg;
	logic [31:0]       rdata;
	logic              addr_phase;
	logic              svc;
	logic              ser_set;
	logic              uart_any_reg;
	logic              uart_pulse_n_reg;
	logic [1:0]        psc_sel_reg;
	logic [1:0]        div4_reg;
	logic              psc_tick;
	logic [1:0]        tb_run_reg;
	logic [2:0]        tb_per_reg [2];
	logic [14:0]       tb_cnt_reg [2];
	logic [1:0]        tb_ovf_reg;

	// a set field of 000 gives 2^8-1, 111 gives 2^15-1
	function automatic logic [14:0] tb_last(input logic [2:0] sel);
		tb_last = `PITB_TB_FULL >> (`PITB_TB_TOPSEL - sel); // [RL18]
	endfunction

	function automatic logic is_wr(input logic [7:0] ofs);
		is_wr = wr_pend_reg && (wr_addr_reg == ofs);
	endfunction

	assign hrdata     = hrdata_reg;
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign irq_req    = irq_req_reg;
	assign irq_vector = irq_vec_reg;
	assign wake       = wake_reg;

	// zero wait states: read data is latched in the address phase
	assign addr_phase = hsel && hready && htrans[1];
	assign svc        = (state_reg == PITB_ST_REQ) && cpu.ack;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= `PITB_RST_BYTE;
		end else begin
			wr_pend_reg <= addr_phase && hwrite;
			wr_addr_reg <= haddr[7:0];
		end
	end

	always_comb begin
		rdata = 32'h0000_0000;
		case (haddr[7:0])
			`PITB_OFS_CTL0: begin
				rdata[`PITB_C0_SERF] = flags_reg[`PITB_SRC_SER];
				rdata[`PITB_C0_SERE] = en_reg[`PITB_SRC_SER];
				rdata[`PITB_C0_GIE]  = gie_reg;
			end
			`PITB_OFS_CTL1: begin
				rdata[`PITB_C12_FHI:`PITB_C12_FLO] = flags_reg[`PITB_SRC_TB0:`PITB_SRC_LOW];
				rdata[`PITB_C12_EHI:`PITB_C12_ELO] = en_reg[`PITB_SRC_TB0:`PITB_SRC_LOW];
			end
			`PITB_OFS_CTL2: begin
				rdata[`PITB_C12_FHI:`PITB_C12_FLO] = flags_reg[`PITB_SRC_T1P:`PITB_SRC_T0A];
				rdata[`PITB_C12_EHI:`PITB_C12_ELO] = en_reg[`PITB_SRC_T1P:`PITB_SRC_T0A];
			end
			`PITB_OFS_CTL3: begin
				rdata[`PITB_C3_URTF] = flags_reg[`PITB_SRC_URT];
				rdata[`PITB_C3_TICK1_REQUEST_FLAG] = flags_reg[`PITB_SRC_TB1];
				rdata[`PITB_C3_URTE] = en_reg[`PITB_SRC_URT];
				rdata[`PITB_C3_TICK1_IRQ_ENABLE] = en_reg[`PITB_SRC_TB1];
			end
			`PITB_OFS_PSC: rdata[`PITB_PSC_HI:`PITB_PSC_LO] = psc_sel_reg;
			`PITB_OFS_TB0: begin
				rdata[`PITB_TB_RUN] = tb_run_reg[0];
				rdata[`PITB_TB_PHI:`PITB_TB_PLO] = tb_per_reg[0];
			end
			`PITB_OFS_TB1: begin
				rdata[`PITB_TB_RUN] = tb_run_reg[1];
				rdata[`PITB_TB_PHI:`PITB_TB_PLO] = tb_per_reg[1];
			end
			`PITB_OFS_PEND: rdata[NSRC-1:0] = pend;
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata_reg <= rdata;
		end
	end

	// one-cycle low pulse in the cycle after the UART conditions go from none to any
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			uart_any_reg     <= 1'b0;
			uart_pulse_n_reg <= 1'b1;
		end else begin
			uart_any_reg     <= |evt.uart_cond;
			uart_pulse_n_reg <= !((|evt.uart_cond) && !uart_any_reg); // [RL6]
		end
	end

	always_comb begin
		if (evt.serial_mode == PITB_MODE_UART) begin
			ser_set = |evt.uart_cond; // [RL2]
		end else begin
			ser_set = evt.sio_byte_done || evt.i2c_addr_match || evt.i2c_timeout; // [RL1]
		end
		// each timer contributes an A and a P match source
		set_vec = {!uart_pulse_n_reg, tb_ovf_reg[1], evt.tmr_match, tb_ovf_reg[0],
			evt.eeprom_wr_done, evt.conv_done, evt.low_supply, ser_set}; // [RL7] [RL8] [RL9] [RL10] [RL11] [RL13]
		clr_vec = svc ? NSRC'(1) << irq_vec_reg : '0; // [RL4] [RL12] [RL14]
	end

	// flags are also software writable; a hardware set beats any clear
	always_comb begin
		flags_next = flags_reg;
		if (is_wr(`PITB_OFS_CTL0)) begin
			flags_next[`PITB_SRC_SER] = hwdata[`PITB_C0_SERF];
		end
		if (is_wr(`PITB_OFS_CTL1)) begin
			flags_next[`PITB_SRC_TB0:`PITB_SRC_LOW] = hwdata[`PITB_C12_FHI:`PITB_C12_FLO];
		end
		if (is_wr(`PITB_OFS_CTL2)) begin
			flags_next[`PITB_SRC_T1P:`PITB_SRC_T0A] = hwdata[`PITB_C12_FHI:`PITB_C12_FLO];
		end
		if (is_wr(`PITB_OFS_CTL3)) begin
			flags_next[`PITB_SRC_URT] = hwdata[`PITB_C3_URTF];
			flags_next[`PITB_SRC_TB1] = hwdata[`PITB_C3_TICK1_REQUEST_FLAG];
		end
		// uart status itself lives in the serial unit and is never touched here
		flags_next = (flags_next & ~clr_vec) | set_vec; // [RL5] [RL20]
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_reg <= `PITB_RST_SRC;
			wake_reg  <= 1'b0;
		end else begin
			flags_reg <= flags_next;
			wake_reg  <= |(flags_next & ~flags_reg); // [RL21]
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_reg <= `PITB_RST_SRC;
		end else begin
			if (is_wr(`PITB_OFS_CTL0)) begin
				en_reg[`PITB_SRC_SER] <= hwdata[`PITB_C0_SERE];
			end
			if (is_wr(`PITB_OFS_CTL1)) begin
				en_reg[`PITB_SRC_TB0:`PITB_SRC_LOW] <= hwdata[`PITB_C12_EHI:`PITB_C12_ELO];
			end
			if (is_wr(`PITB_OFS_CTL2)) begin
				en_reg[`PITB_SRC_T1P:`PITB_SRC_T0A] <= hwdata[`PITB_C12_EHI:`PITB_C12_ELO];
			end
			if (is_wr(`PITB_OFS_CTL3)) begin
				en_reg[`PITB_SRC_URT] <= hwdata[`PITB_C3_URTE];
				en_reg[`PITB_SRC_TB1] <= hwdata[`PITB_C3_TICK1_IRQ_ENABLE];
			end
		end
	end

	// service clear wins over a software write and a return in the same cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gie_reg <= 1'b0;
		end else if (svc) begin
			gie_reg <= 1'b0; // [RL4] [RL7] [RL12] [RL14]
		end else if (cpu.reti) begin
			gie_reg <= 1'b1;
		end else if (is_wr(`PITB_OFS_CTL0)) begin
			gie_reg <= hwdata[`PITB_C0_GIE];
		end
	end

	always_comb begin
		pend   = flags_reg & en_reg;
		lowest = 4'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (pend[i]) begin
				lowest = 4'(i); // [RL22]
			end
		end
	end

	// vector is frozen while waiting for the ack
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg   <= PITB_ST_IDLE;
			irq_req_reg <= 1'b0;
			irq_vec_reg <= 4'h0;
		end else begin
			case (state_reg)
				PITB_ST_IDLE: begin
					if (gie_reg && !cpu.stack_full && |pend) begin // [RL3] [RL7] [RL14] [RL20]
						state_reg   <= PITB_ST_REQ;
						irq_req_reg <= 1'b1;
						irq_vec_reg <= lowest; // [RL22]
					end
				end
				PITB_ST_REQ: begin
					if (cpu.ack) begin
						state_reg   <= PITB_ST_IDLE;
						irq_req_reg <= 1'b0;
					end
				end
				default: begin
					state_reg   <= PITB_ST_IDLE;
					irq_req_reg <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			psc_sel_reg <= 2'h0;
		end else if (is_wr(`PITB_OFS_PSC)) begin
			psc_sel_reg <= hwdata[`PITB_PSC_HI:`PITB_PSC_LO];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div4_reg <= 2'h0;
		end else begin
			div4_reg <= div4_reg + 2'h1;
		end
	end

	always_comb begin
		case (psc_sel_reg)
			`PITB_PSC_SYS:  psc_tick = 1'b1; // [RL15]
			`PITB_PSC_DIV4: psc_tick = (div4_reg == `PITB_DIV4_LAST);
			default:        psc_tick = sub_tick;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tb_run_reg <= 2'h0;
			tb_per_reg <= '{3'h0, 3'h0};
		end else begin
			if (is_wr(`PITB_OFS_TB0)) begin
				tb_run_reg[0] <= hwdata[`PITB_TB_RUN]; // [RL17]
				tb_per_reg[0] <= hwdata[`PITB_TB_PHI:`PITB_TB_PLO];
			end
			if (is_wr(`PITB_OFS_TB1)) begin
				tb_run_reg[1] <= hwdata[`PITB_TB_RUN]; // [RL19]
				tb_per_reg[1] <= hwdata[`PITB_TB_PHI:`PITB_TB_PLO];
			end
		end
	end

	// a stopped unit restarts its period from zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tb_cnt_reg <= '{15'h0000, 15'h0000};
			tb_ovf_reg <= 2'h0;
		end else begin
			for (int u = 0; u < 2; u++) begin
				tb_ovf_reg[u] <= 1'b0;
				if (!tb_run_reg[u]) begin
					tb_cnt_reg[u] <= 15'h0000; // [RL17] [RL19]
				end else if (psc_tick) begin // [RL16]
					if (tb_cnt_reg[u] == tb_last(tb_per_reg[u])) begin
						tb_cnt_reg[u] <= 15'h0000;
						tb_ovf_reg[u] <= 1'b1; // [RL13]
					end else begin
						tb_cnt_reg[u] <= tb_cnt_reg[u] + 15'h0001; // [RL18]
					end
				end
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	serial_spi_set_a: assert property ((evt.serial_mode != PITB_MODE_UART) && evt.sio_byte_done
		|=> flags_reg[`PITB_SRC_SER]) else $error("serial byte event lost"); // [RL1]
	serial_uart_set_a: assert property ((evt.serial_mode == PITB_MODE_UART) && |evt.uart_cond
		|=> flags_reg[`PITB_SRC_SER]) else $error("uart condition lost on serial flag"); // [RL2]
	vector_gate_a: assert property ($rose(irq_req_reg) |-> $past(gie_reg) && !$past(cpu.stack_full)
		&& $past(pend[lowest])) else $error("request without qualification"); // [RL3]
	service_clear_a: assert property (svc |=> !gie_reg && !irq_req_reg)
		else $error("service left global enable set"); // [RL4]
	uart_pulse_a: assert property ($rose(|evt.uart_cond) |=> !uart_pulse_n_reg ##1 uart_pulse_n_reg
		##1 flags_reg[`PITB_SRC_URT] || svc) else $error("uart pulse malformed"); // [RL6]
	low_flag_a: assert property (evt.low_supply |=> flags_reg[`PITB_SRC_LOW])
		else $error("low supply flag not set"); // [RL8]
	flag_auto_clr_a: assert property (svc && !set_vec[irq_vec_reg] && !wr_pend_reg
		|=> !flags_reg[$past(irq_vec_reg)]) else $error("serviced flag not cleared"); // [RL12]
	tick_flag_a: assert property (tb_ovf_reg[0] |=> flags_reg[`PITB_SRC_TB0])
		else $error("time base 0 flag not set"); // [RL13]
	tick_stop_a: assert property (!tb_run_reg[0] |=> tb_cnt_reg[0] == 15'h0000 && !tb_ovf_reg[0])
		else $error("stopped time base counts"); // [RL17]
	tick_period_a: assert property (tb_run_reg[0] && psc_sel_reg == `PITB_PSC_SYS && tb_per_reg[0] == 3'h0
		&& tb_cnt_reg[0] == 15'h00FF |=> tb_ovf_reg[0]) else $error("time base 0 period wrong"); // [RL18]
	global_off_a: assert property (!gie_reg && state_reg == PITB_ST_IDLE |=> !irq_req_reg)
		else $error("request while globally disabled"); // [RL20]
	wake_rise_a: assert property (|(flags_next & ~flags_reg) |=> wake_reg)
		else $error("rising flag gave no wake"); // [RL21]
	lowest_first_a: assert property ($rose(irq_req_reg) |-> irq_vec_reg == $past(lowest))
		else $error("vector not lowest pending"); // [RL22]

	svc_cover: cover property (svc ##1 cpu.reti);
	nest_cover: cover property (irq_req_reg && pend[`PITB_SRC_SER] && pend[`PITB_SRC_URT]);
	tick1_cover: cover property (tb_ovf_reg[1] && psc_sel_reg == `PITB_PSC_DIV4);
endmodule

// ---- testbench/pitb_cpu_model.sv ----
// sequencer model: takes a pending request after a set wait, returns on demand
// assumes irq_req holds until the edge after ack and the vector is valid meanwhile
`timescale 1ns/1ns
module pitb_cpu_model (
	input  wire logic           clk,
	input  wire logic           sys_rst,
	input  wire logic           irq_req,
	input  wire logic [3:0]     irq_vector,
	input  wire logic [3:0]     ack_wait,
	input  wire logic           stack_full,
	input  wire logic           reti_go,
	output pitb_pkg::pitb_cpu_t cpu,
	output logic      [3:0]     last_vec
);
	import pitb_pkg::*;
	logic       ack_reg;
	logic [3:0] wait_reg;
	// one ack per request; the wait restarts once irq_req drops
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_reg  <= 1'b0;
			wait_reg <= 4'h0;
			last_vec <= 4'h0;
		end else begin
			ack_reg <= 1'b0;
			if (!irq_req || ack_reg) begin
				wait_reg <= 4'h0;
			end else if (wait_reg >= ack_wait) begin
				ack_reg  <= 1'b1;
				last_vec <= irq_vector;
			end else begin
				wait_reg <= wait_reg + 4'h1;
			end
		end
	end
	assign cpu = '{stack_full: stack_full, ack: ack_reg, reti: reti_go};
endmodule

// ---- testbench/peripheral_interrupt_and_time_base_tb.sv ----
// self-checking bench for the interrupt and time base block
// assumes zero-wait bus slave and the source map of the map header
`timescale 1ns/1ns
`include "pitb_map.svh"
module peripheral_interrupt_and_time_base_tb;
	import pitb_pkg::*;
	logic        clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, sub_tick = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [3:0]  ack_wait = 4'h0, irq_vector, last_vec;
	logic        stack_full = 1'b0, reti_go = 1'b0, hready, hreadyout, irq_req, wake, hresp;
	logic [31:0] hrdata, d;
	pitb_evt_t   evt = '0;
	pitb_cpu_t   cpu;
	int          errors = 0, checked = 0, cyc = 0, wake_n = 0, sub_cnt = 0, t0, w;
	assign hready = hreadyout;
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		sub_cnt <= (sub_cnt == 2) ? 0 : sub_cnt + 1;
		sub_tick <= (sub_cnt == 2);
		if (wake === 1'b1) wake_n <= wake_n + 1;
	end
	pitb_top uut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.evt(evt), .sub_tick(sub_tick), .cpu(cpu), .irq_req(irq_req), .irq_vector(irq_vector), .wake(wake));
	pitb_cpu_model partner (.clk(clk), .sys_rst(sys_rst), .irq_req(irq_req), .irq_vector(irq_vector),
		.ack_wait(ack_wait), .stack_full(stack_full), .reti_go(reti_go), .cpu(cpu), .last_vec(last_vec));
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		d = hrdata;
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		chk(nm, exp, d);
	endtask
	// event codes: 0..10 source index except time bases 4 and 9, 11/12 i2c events, 20..25 uart conditions
	task automatic ev(input int k, input logic v);
		case (k)
			0: evt.sio_byte_done <= v;
			1: evt.low_supply <= v;
			2: evt.conv_done <= v;
			3: evt.eeprom_wr_done <= v;
			5, 6, 7, 8: evt.tmr_match[k-5] <= v;
			10: evt.uart_cond[0] <= v;
			11: evt.i2c_addr_match <= v;
			12: evt.i2c_timeout <= v;
			default: evt.uart_cond[k-20] <= v;
		endcase
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		ev(k, 1'b1);
		@(posedge clk);
		ev(k, 1'b0);
	endtask
	task automatic wait_irq(input logic lvl, input int lim);
		int n;
		n = 0;
		while (irq_req !== lvl && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk("irq_req", {31'h0, lvl}, {31'h0, irq_req});
	endtask
	task automatic reti();
		@(posedge clk);
		reti_go <= 1'b1;
		@(posedge clk);
		reti_go <= 1'b0;
	endtask
	function automatic logic [7:0] en_addr(input int i);
		return i == 0 ? `PITB_OFS_CTL0 : i <= 4 ? `PITB_OFS_CTL1 : i <= 8 ? `PITB_OFS_CTL2 : `PITB_OFS_CTL3;
	endfunction
	function automatic int en_bit(input int i);
		return i == 0 ? 3 : i <= 4 ? i - 1 : i <= 8 ? i - 5 : i - 9;
	endfunction
	task automatic reset_values();
		repeat (300) @(posedge clk);
		for (int k = 0; k < 9; k++) rd_chk("reset value", 8'(k * 4), 32'h0);
		chk("hresp", 32'h0, {31'h0, hresp});
		bus(`PITB_OFS_TB0, 1'b1, 32'h7F);
		rd_chk("tick0 control", `PITB_OFS_TB0, 32'h07);
		bus(`PITB_OFS_PSC, 1'b1, 32'hFF);
		rd_chk("prescaler select", `PITB_OFS_PSC, 32'h03);
		bus(`PITB_OFS_TB0, 1'b1, 32'h0);
		bus(`PITB_OFS_PSC, 1'b1, 32'h0);
	endtask
	task automatic serial_modes();
		for (int m = 0; m < 2; m++) begin
			evt.serial_mode <= pitb_mode_t'(m);
			for (int e = 0; e < 3; e++) begin
				pulse(e == 0 ? 0 : 10 + e);
				repeat (2) @(posedge clk);
				rd_chk("serial flag", `PITB_OFS_CTL0, 32'h40);
				bus(`PITB_OFS_CTL0, 1'b1, 32'h0);
			end
		end
		evt.serial_mode <= PITB_MODE_UART;
		for (int b = 0; b < 6; b++) begin
			pulse(20 + b);
			repeat (3) @(posedge clk);
			rd_chk("serial flag uart", `PITB_OFS_CTL0, 32'h40);
			rd_chk("uart flag", `PITB_OFS_CTL3, 32'h20);
			bus(`PITB_OFS_CTL0, 1'b1, 32'h0);
			bus(`PITB_OFS_CTL3, 1'b1, 32'h0);
		end
		bus(`PITB_OFS_CTL3, 1'b1, 32'h02);
		bus(`PITB_OFS_CTL0, 1'b1, 32'h01);
		pulse(20);
		wait_irq(1'b1, 20);
		chk("uart vector", 10, {28'h0, irq_vector});
		wait_irq(1'b0, 20);
		rd_chk("serial flag kept", `PITB_OFS_CTL0, 32'h40);
		rd_chk("uart flag cleared", `PITB_OFS_CTL3, 32'h02);
		bus(`PITB_OFS_CTL0, 1'b1, 32'h0);
		bus(`PITB_OFS_CTL3, 1'b1, 32'h0);
		evt.serial_mode <= PITB_MODE_SPI;
		chk("no request while disabled", 32'h0, {31'h0, irq_req});
	endtask
	task automatic service(input int i);
		w = wake_n;
		if (i != 0) bus(en_addr(i), 1'b1, 32'h1 << en_bit(i));
		bus(`PITB_OFS_CTL0, 1'b1, i == 0 ? 32'h09 : 32'h01);
		pulse(i);
		wait_irq(1'b1, 20);
		chk("vector", i, {28'h0, irq_vector});
		wait_irq(1'b0, 20);
		chk("acked vector", i, {28'h0, last_vec});
		rd_chk("flag after service", en_addr(i), 32'h1 << en_bit(i));
		if (i != 0) rd_chk("global enable", `PITB_OFS_CTL0, 32'h0);
		chk("wake pulses", 1, wake_n - w);
		bus(en_addr(i), 1'b1, 32'h0);
	endtask
	task automatic gating();
		stack_full <= 1'b1;
		bus(`PITB_OFS_CTL1, 1'b1, 32'h02);
		bus(`PITB_OFS_CTL0, 1'b1, 32'h01);
		pulse(2);
		repeat (10) @(posedge clk);
		chk("request with stack full", 32'h0, {31'h0, irq_req});
		stack_full <= 1'b0;
		wait_irq(1'b1, 20);
		wait_irq(1'b0, 20);
		bus(`PITB_OFS_CTL1, 1'b1, 32'h0);
	endtask
	task automatic priority_order();
		ack_wait <= 4'h5;
		bus(`PITB_OFS_CTL1, 1'b1, 32'h05);
		bus(`PITB_OFS_CTL2, 1'b1, 32'h08);
		@(posedge clk);
		ev(1, 1'b1);
		ev(3, 1'b1);
		ev(8, 1'b1);
		@(posedge clk);
		ev(1, 1'b0);
		ev(3, 1'b0);
		ev(8, 1'b0);
		repeat (5) @(posedge clk);
		chk("request while global off", 32'h0, {31'h0, irq_req});
		rd_chk("pending", `PITB_OFS_PEND, 32'h10A);
		bus(`PITB_OFS_CTL0, 1'b1, 32'h01);
		for (int k = 0; k < 3; k++) begin
			wait_irq(1'b1, 20);
			chk("priority vector", k == 0 ? 1 : k == 1 ? 3 : 8, {28'h0, irq_vector});
			wait_irq(1'b0, 20);
			reti();
		end
		rd_chk("flags after all", `PITB_OFS_CTL1, 32'h05);
		bus(`PITB_OFS_CTL0, 1'b1, 32'h0);
		bus(`PITB_OFS_CTL1, 1'b1, 32'h0);
		bus(`PITB_OFS_CTL2, 1'b1, 32'h0);
		ack_wait <= 4'h0;
	endtask
	task automatic tick_period(input int u, input logic [1:0] psc, input logic [2:0] sel, input int exp);
		logic [7:0] ta, ea;
		ta = u ? `PITB_OFS_TB1 : `PITB_OFS_TB0;
		ea = u ? `PITB_OFS_CTL3 : `PITB_OFS_CTL1;
		bus(`PITB_OFS_PSC, 1'b1, {30'h0, psc});
		bus(ta, 1'b1, {24'h0, 5'h10, sel});
		bus(ea, 1'b1, u ? 32'h01 : 32'h08);
		bus(`PITB_OFS_CTL0, 1'b1, 32'h01);
		wait_irq(1'b1, exp + 50);
		t0 = cyc;
		wait_irq(1'b0, 20);
		reti();
		wait_irq(1'b1, exp + 50);
		chk("tick period", exp, cyc - t0);
		chk("tick vector", u ? 9 : 4, {28'h0, irq_vector});
		wait_irq(1'b0, 20);
		bus(ta, 1'b1, 32'h0);
		bus(ea, 1'b1, 32'h0);
		rd_chk("global after tick", `PITB_OFS_CTL0, 32'h0);
	endtask
	initial begin
		repeat (95000) @(posedge clk);
		errors++;
		$display("watchdog expired");
		close_out();
	end
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		reset_values();
		serial_modes();
		for (int j = 0; j < 9; j++) service(j < 4 ? j : j < 8 ? j + 1 : 10);
		gating();
		priority_order();
		tick_period(0, 2'h0, 3'h0, 256);
		tick_period(0, 2'h0, 3'h1, 512);
		tick_period(0, 2'h0, 3'h7, 32768);
		tick_period(1, 2'h1, 3'h0, 1024);
		tick_period(1, 2'h2, 3'h0, 768);
		tick_period(1, 2'h3, 3'h1, 1536);
		close_out();
	end
endmodule
